// >>> rtl/plc_link_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: Half duplex flags collision while transmit and receive are both active.
// RULE_02: Full duplex never flags a collision.
// RULE_03: Half duplex asserts carrier sense while sending or receiving.
// RULE_04: Full duplex asserts carrier sense only while receiving.
// RULE_05: Advertise own modes, acknowledge shared ones, reject unshared ones.
// RULE_06: Several common modes resolve to one by fixed priority; link uses it.
// RULE_07: Silent partner: parallel detect the incoming technology, link if supported.
// RULE_08: Detect straight or crossed cable and set pair assignment to match.
// RULE_09: A control bit forces MDI or MDIX instead of automatic selection.
// RULE_10: Automatic toggle timing derives from a 16-bit LFSR.
// RULE_11: Each toggle interval lasts 200 ms to 420 ms, pseudo-random.
// RULE_12: Automatic mode keeps toggling until a valid received signal appears.
// RULE_13: Once signal is seen, hold the assignment until the link is lost. The code holds until both link and received signal are lost.
module plc_link_ctrl (
  input  wire logic                        i_mclk,
  input  wire logic                        i_reset_n,
  input  wire logic                        i_tx_active,
  input  wire logic                        i_rx_active,
  input  wire logic                        i_an_enable,
  input  wire logic [plc_pkg::ABIL_W-1:0]  i_local_abil,
  input  wire logic                        i_partner_page_valid,
  input  wire logic [plc_pkg::ABIL_W-1:0]  i_partner_abil,
  input  wire logic [1:0]                  i_rx_tech,
  input  wire logic                        i_sig_det,
  input  wire logic                        i_link_ok,
  input  wire logic [1:0]                  i_xsel,
  input  wire logic                        i_force_fdx,
  input  wire logic                        i_force_100,
  output logic                             o_col,
  output logic                             o_crs,
  output logic [plc_pkg::ABIL_W-1:0]       o_adv_abil,
  output logic [plc_pkg::ABIL_W-1:0]       o_ack_abil,
  output logic                             o_ack,
  output logic                             o_link_up,
  output logic                             o_fdx,
  output logic                             o_speed_100,
  output logic                             o_par_det,
  output logic                             o_mdix
);
  plc_pkg::plc_an_state_t          st, next_st;
  logic [plc_pkg::ABIL_W-1:0]      ack_abil, next_ack_abil;
  logic                            ack, next_ack;
  logic                            link_up, next_link_up;
  logic                            fdx, next_fdx;
  logic                            spd, next_spd;
  logic                            par, next_par;
  logic                            col, next_col;
  logic                            crs, next_crs;
  logic [plc_pkg::ABIL_W-1:0]      common;

  assign common = i_local_abil & i_partner_abil; // see RULE_05

  always_comb begin
    next_st       = st;
    next_ack_abil = ack_abil;
    next_ack      = ack;
    next_link_up  = link_up;
    next_fdx      = fdx;
    next_spd      = spd;
    next_par      = par;
    if (!i_an_enable) begin
      next_st      = plc_pkg::AN_IDLE;
      next_ack     = 1'b0;
      next_par     = 1'b0;
      next_fdx     = i_force_fdx;
      next_spd     = i_force_100;
      next_link_up = i_link_ok;
    end else begin
      case (st)
        plc_pkg::AN_IDLE: begin
          next_ack     = 1'b0;
          next_link_up = 1'b0;
          next_par     = 1'b0;
          next_st      = plc_pkg::AN_WAIT;
        end
        plc_pkg::AN_WAIT: begin
          if (i_partner_page_valid) begin
            // Unshared modes are dropped from the acknowledged set
            next_ack_abil = common; // see RULE_05
            next_ack      = 1'b1;
            if (common != '0) begin
              next_st      = plc_pkg::AN_UP;
              next_link_up = 1'b1;
              if (common[plc_pkg::AB_100FD]) begin // see RULE_06
                next_spd = 1'b1;
                next_fdx = 1'b1;
              end else if (common[plc_pkg::AB_100HD]) begin
                next_spd = 1'b1;
                next_fdx = 1'b0;
              end else if (common[plc_pkg::AB_10FD]) begin
                next_spd = 1'b0;
                next_fdx = 1'b1;
              end else begin
                next_spd = 1'b0;
                next_fdx = 1'b0;
              end
            end
          end else if (i_rx_tech == plc_pkg::TECH_100
                       && (i_local_abil[plc_pkg::AB_100HD]
                           || i_local_abil[plc_pkg::AB_100FD])) begin
            // Either duplex ability means the technology is supported;
            // a non-negotiating partner still implies half duplex
            next_st      = plc_pkg::AN_UP; // see RULE_07
            next_par     = 1'b1;
            next_link_up = 1'b1;
            next_spd     = 1'b1;
            next_fdx     = 1'b0;
          end else if (i_rx_tech == plc_pkg::TECH_10
                       && (i_local_abil[plc_pkg::AB_10HD]
                           || i_local_abil[plc_pkg::AB_10FD])) begin
            next_st      = plc_pkg::AN_UP; // see RULE_07
            next_par     = 1'b1;
            next_link_up = 1'b1;
            next_spd     = 1'b0;
            next_fdx     = 1'b0;
          end
        end
        plc_pkg::AN_UP: begin
          if (!i_link_ok) begin
            next_st      = plc_pkg::AN_IDLE;
            next_link_up = 1'b0;
          end
        end
        default: next_st = plc_pkg::AN_IDLE;
      endcase
    end
  end

  always_comb begin
    if (fdx) begin
      next_col = 1'b0; // see RULE_02
      next_crs = i_rx_active; // see RULE_04
    end else begin
      next_col = i_tx_active & i_rx_active; // see RULE_01
      next_crs = i_tx_active | i_rx_active; // see RULE_03
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      st         <= plc_pkg::AN_IDLE;
      ack_abil   <= '0;
      ack        <= 1'b0;
      link_up    <= 1'b0;
      fdx        <= 1'b0;
      spd        <= 1'b0;
      par        <= 1'b0;
      col        <= 1'b0;
      crs        <= 1'b0;
      o_adv_abil <= '0;
    end else begin
      st         <= next_st;
      ack_abil   <= next_ack_abil;
      ack        <= next_ack;
      link_up    <= next_link_up;
      fdx        <= next_fdx;
      spd        <= next_spd;
      par        <= next_par;
      col        <= next_col;
      crs        <= next_crs;
      o_adv_abil <= i_local_abil; // see RULE_05
    end
  end

  assign o_col       = col;
  assign o_crs       = crs;
  assign o_ack_abil  = ack_abil;
  assign o_ack       = ack;
  assign o_link_up   = link_up;
  assign o_fdx       = fdx;
  assign o_speed_100 = spd;
  assign o_par_det   = par;

  plc_mdix u_mdix (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_xsel    (i_xsel),
    .i_sig_det (i_sig_det),
    .i_link_up (link_up),
    .o_mdix    (o_mdix)
  );
endmodule : plc_link_ctrl

// >>> rtl/plc_pkg.sv
package plc_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned MDIX_MIN_MS     = 200;
  localparam int unsigned MDIX_MAX_MS     = 420;
  localparam int unsigned MDIX_MIN_CYC    = MDIX_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned MDIX_MAX_CYC    = MDIX_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned MDIX_SPAN_CYC   = MDIX_MAX_CYC - MDIX_MIN_CYC;
  localparam int unsigned LFSR_W          = 16;
  localparam logic [15:0] LFSR_SEED       = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS       = 16'hB400;
  localparam int unsigned TMR_W           = 23;
  localparam int unsigned ABIL_W          = 4;
  // Ability bits in priority order, highest index wins
  localparam int unsigned AB_10HD         = 0;
  localparam int unsigned AB_10FD         = 1;
  localparam int unsigned AB_100HD        = 2;
  localparam int unsigned AB_100FD        = 3;
  localparam logic [1:0]  TECH_NONE       = 2'h0;
  localparam logic [1:0]  TECH_10         = 2'h1;
  localparam logic [1:0]  TECH_100        = 2'h2;
  typedef enum logic [1:0] {XS_AUTO, XS_MDI, XS_MDIX} plc_xsel_t;
  typedef enum {AN_IDLE, AN_WAIT, AN_UP} plc_an_state_t;
endpackage : plc_pkg

// >>> rtl/plc_mdix.sv
`timescale 1ns/1ps
module plc_mdix (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset_n,
  input  wire logic [1:0]           i_xsel,
  input  wire logic                 i_sig_det,
  input  wire logic                 i_link_up,
  output logic                      o_mdix
);
  logic [plc_pkg::LFSR_W-1:0] lfsr, next_lfsr;
  logic [plc_pkg::TMR_W-1:0]  tmr, next_tmr;
  logic                       mdix, next_mdix;
  logic                       held, next_held;
  logic [plc_pkg::TMR_W-1:0]  reload;

  // Random part scaled into the 220 ms span: span * lfsr / 2^16
  always_comb begin
    reload = plc_pkg::TMR_W'(plc_pkg::MDIX_MIN_CYC
           + ((64'(plc_pkg::MDIX_SPAN_CYC) * 64'(lfsr)) >> plc_pkg::LFSR_W)); // see RULE_11
  end

  always_comb begin
    next_lfsr = {lfsr[plc_pkg::LFSR_W-2:0], ^(lfsr & plc_pkg::LFSR_TAPS)}; // see RULE_10
    next_tmr  = tmr;
    next_mdix = mdix;
    next_held = held;
    if (i_xsel == plc_pkg::XS_MDI) begin
      next_mdix = 1'b0; // see RULE_09
      next_held = 1'b0;
    end else if (i_xsel == plc_pkg::XS_MDIX) begin
      next_mdix = 1'b1; // see RULE_09
      next_held = 1'b0;
    end else if (held) begin
      // Hold while signal or link stays up; losing both restarts hunting
      if (!i_sig_det && !i_link_up) begin
        next_held = 1'b0; // see RULE_13
        next_tmr  = reload;
      end
    end else if (i_sig_det) begin
      next_held = 1'b1; // see RULE_13
    end else if (tmr == '0) begin
      next_mdix = ~mdix; // see RULE_12
      next_tmr  = reload; // see RULE_08
    end else begin
      next_tmr = tmr - 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      lfsr <= plc_pkg::LFSR_SEED;
      tmr  <= plc_pkg::TMR_W'(plc_pkg::MDIX_MIN_CYC);
      mdix <= 1'b0;
      held <= 1'b0;
    end else begin
      lfsr <= next_lfsr;
      tmr  <= next_tmr;
      mdix <= next_mdix;
      held <= next_held;
    end
  end

  assign o_mdix = mdix;
endmodule : plc_mdix

// >>> testbench/plc_link_chk.sv
`timescale 1ns/1ps
module plc_link_chk (
  input wire logic       i_mclk,
  input wire logic       i_reset_n,
  input wire logic       i_tx_active,
  input wire logic       i_rx_active,
  input wire logic [3:0] i_local_abil,
  input wire logic [3:0] i_partner_abil,
  input wire logic [1:0] i_rx_tech,
  input wire logic       i_sig_det,
  input wire logic [1:0] i_xsel,
  input wire logic       o_col,
  input wire logic       o_crs,
  input wire logic [3:0] o_adv_abil,
  input wire logic [3:0] o_ack_abil,
  input wire logic       o_ack,
  input wire logic       o_link_up,
  input wire logic       o_fdx,
  input wire logic       o_speed_100,
  input wire logic       o_par_det,
  input wire logic       o_mdix
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  AST_HDX: assert property (!$past(o_fdx) && !o_fdx |-> o_col ==
    ($past(i_tx_active) & $past(i_rx_active)) && o_crs == ($past(i_tx_active) | $past(i_rx_active)))
    else $error("half duplex col or crs");
  AST_FDX: assert property ($past(o_fdx) && o_fdx |-> !o_col && o_crs == $past(i_rx_active))
    else $error("full duplex col or crs");
  AST_ADV: assert property ($past(i_reset_n) |-> o_adv_abil == $past(i_local_abil))
    else $error("advert");
  AST_ACK: assert property ($rose(o_ack) |-> o_ack_abil == ($past(i_local_abil) & $past(i_partner_abil)))
    else $error("ack set");
  AST_PRIO: assert property ($rose(o_link_up) && o_ack && !o_par_det |-> o_speed_100 ==
    (|o_ack_abil[3:2]) && o_fdx == (o_ack_abil[3] | !o_ack_abil[2] & o_ack_abil[1]))
    else $error("priority");
  AST_PAR: assert property ($rose(o_par_det) |-> o_link_up && !o_fdx &&
    o_speed_100 == ($past(i_rx_tech) == plc_pkg::TECH_100)) else $error("parallel");
  AST_FORCE: assert property ($past(i_xsel) inside {2'h1, 2'h2} |-> o_mdix == ($past(i_xsel) == 2'h2))
    else $error("force");
  AST_HOLD: assert property ($past(i_sig_det) && $past(i_xsel) inside {2'h0, 2'h3} |-> $stable(o_mdix))
    else $error("hold");
endmodule : plc_link_chk
bind plc_link_ctrl plc_link_chk u_chk (.*);

// >>> testbench/plc_partner.sv
`timescale 1ns/1ps
module plc_partner (
  input  wire logic       i_mclk,
  input  wire logic       i_go,
  input  wire logic       i_silent,
  input  wire logic [3:0] i_abil,
  input  wire logic [1:0] i_tech,
  input  wire logic [3:0] i_wait,
  output logic            o_page_valid = 1'h0,
  output logic [3:0]      o_abil = 4'h0,
  output logic [1:0]      o_rx_tech = 2'h0,
  output logic            o_sig_det = 1'h0
);
  logic [3:0] cnt = 4'h0;
  wire        rdy = i_go && cnt == i_wait;
  // Undriven word toggles so a stale page is never read as valid
  always @(posedge i_mclk) begin
    cnt <= i_go ? cnt + {3'h0, !rdy} : 4'h0;
    o_page_valid <= rdy && !i_silent;
    o_abil <= (i_go && !i_silent) ? i_abil : ~o_abil;
    o_rx_tech <= (rdy && i_silent) ? i_tech : plc_pkg::TECH_NONE;
    o_sig_det <= rdy;
  end
endmodule : plc_partner

// >>> testbench/plc_link_ctrl_tb.sv
`timescale 1ns/1ps
module plc_link_ctrl_tb;
  logic       i_mclk = '0, i_reset_n = '0, tx = '0, rx = '0, an = '0, lok = '0, ffdx = '0;
  logic       go = '0, sil = '0, lk = '0, pv, sd, col, crs, ack, lnk, fdx, spd, pd, mdx;
  logic [3:0] la = '0, pa = '0, wt = '0, c, pab, adv, aab;
  logic [1:0] xs = '0, tech = '0, rt;
  logic [6:0] qcc[$], qln[$];
  int         num_errors = 0, check_count = 0, seed = 17737, i, n;
  localparam logic [19:0] TL = 20'hC136F, TP = 20'h3127F;
  always #50 i_mclk = ~i_mclk;
  plc_partner u_far (.i_mclk(i_mclk), .i_go(go), .i_silent(sil), .i_abil(pa), .i_tech(tech),
    .i_wait(wt), .o_page_valid(pv), .o_abil(pab), .o_rx_tech(rt), .o_sig_det(sd));
  plc_link_ctrl DUT (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_tx_active(tx), .i_rx_active(rx),
    .i_an_enable(an), .i_local_abil(la), .i_partner_page_valid(pv), .i_partner_abil(pab),
    .i_rx_tech(rt), .i_sig_det(sd), .i_link_ok(lok), .i_xsel(xs), .i_force_fdx(ffdx),
    .i_force_100(1'h0), .o_col(col), .o_crs(crs), .o_adv_abil(adv), .o_ack_abil(aab),
    .o_ack(ack), .o_link_up(lnk), .o_fdx(fdx), .o_speed_100(spd), .o_par_det(pd), .o_mdix(mdx));
  task automatic cyc(input int k);
    repeat (k) @(negedge i_mclk);
  endtask : cyc
  task cmp(input logic [6:0] got, input logic [6:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %h %h", $time, got, exp);
    end
  endtask : cmp
  task test_done;
    if (num_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  always @(posedge i_mclk) begin
    #1;
    if (qcc.size() > 0) cmp({5'h0, col, crs}, qcc.pop_front());
    if (an && lnk && !lk) cmp({aab, fdx, spd, pd}, qln.pop_front());
    lk = lnk;
  end
  initial begin
    cyc(2);
    i_reset_n = 1'h1;
    lok = 1'h1;
    for (n = 0; n < 2; n++) begin
      ffdx = n[0];
      cyc(3);
      for (i = 0; i < 24; i++) begin
        {tx, rx} = 2'($random(seed));
        qcc.push_back({5'h0, tx & rx & !ffdx, rx | tx & !ffdx});
        cyc(1);
      end
    end
    cmp({6'h0, mdx}, 7'h0);
    for (n = 0; n < 9; n++) begin
      {an, lok, go, sil} = '0;
      cyc(3);
      {la, pa} = (n < 5) ? {TL[4*n +: 4], TP[4*n +: 4]} : 8'($random(seed));
      la = la | {3'h0, la == 4'h0};
      c = la & pa;
      tech = (|la[3:2]) ? plc_pkg::TECH_100 : plc_pkg::TECH_10;
      wt = 4'($random(seed)) & 4'h7;
      qln.push_back((c != 4'h0) ? {c, c[3] | !c[2] & c[1], |c[3:2], 1'h0} : {5'h0, |la[3:2], 1'h1});
      {an, lok, go} = '1;
      if (c == 4'h0) begin
        cyc(wt + 4);
        cmp({6'h0, ack & !lnk}, 7'h1);
        sil = 1'h1;
      end
      for (i = 0; i < 30 && !lnk; i++) cyc(1);
      if (!lnk) begin
        num_errors++;
        test_done;
      end
    end
    {an, go} = '0;
    for (n = 1; n < 3; n++) begin
      xs = n[1:0];
      cyc(2);
      cmp({6'h0, mdx}, {6'h0, n == 2});
    end
    test_done;
  end
endmodule : plc_link_ctrl_tb
